// *** shared/pec_pkg.sv ***
package pec_pkg;

	// register byte offsets on the control bus
	localparam int         ADDR_W       = 8;
	localparam logic [7:0] OFF_A_RISE   = 8'h00;
	localparam logic [7:0] OFF_A_FALL   = 8'h04;
	localparam logic [7:0] OFF_A_FLAGS  = 8'h08;
	localparam logic [7:0] OFF_B_RISE   = 8'h0C;
	localparam logic [7:0] OFF_B_FALL   = 8'h10;
	localparam logic [7:0] OFF_B_FLAGS  = 8'h14;
	localparam logic [7:0] OFF_CTRL     = 8'h18;

	// field layout: port a pins in bits 5:0, port b pins in bits 7:4
	localparam int         A_LSB        = 0;
	localparam int         A_W          = 6;
	localparam int         B_LSB        = 4;
	localparam int         B_W          = 4;

	// control register bits
	localparam int         CTRL_EN_BIT  = 0;
	localparam int         CTRL_PND_BIT = 1;

	// reset values
	localparam logic [7:0] REG_RST      = 8'h00;

	// bus response codes
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;

	// bus channel states, one-hot
	typedef enum logic [1:0] {
		PEC_CH_IDLE = 2'b01,
		PEC_CH_RESP = 2'b10
	} pec_ch_e;

endpackage

// *** shared/pec_edge_if.sv ***
`timescale 1ns/1ps
// edge pulses from a pin detector to the flag logic
interface pec_edge_if #(
	parameter int W = 6
);
	logic [W-1:0] rise;
	logic [W-1:0] fall;

	modport det (output rise, output fall);
	modport use_side (input rise, input fall);
endinterface

// *** hw/pec_edge_detect.sv ***
`timescale 1ns/1ps
// per-pin synchroniser and edge detector
module pec_edge_detect #(
	parameter int W = 6
) (
	// clock and reset
	input  wire logic         mclk_in,
	input  wire logic         sys_rst_in,
	// raw pins
	input  wire logic [W-1:0] pins_in,
	// edge pulses
	pec_edge_if.det           edges
);

	logic [W-1:0] sync1_q;
	logic [W-1:0] sync2_q;
	logic [W-1:0] prev_q;

	// three flops per pin; the first is read only by the second
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			sync1_q <= '0;
			sync2_q <= '0;
			prev_q  <= '0;
		end else begin
			sync1_q <= pins_in;
			sync2_q <= sync1_q;
			prev_q  <= sync2_q;
		end
	end

	// compare current sample with the previous one
	for (genvar i = 0; i < W; i++) begin : g_pin
		assign edges.rise[i] = sync2_q[i] & ~prev_q[i];
		assign edges.fall[i] = ~sync2_q[i] & prev_q[i];
	end

endmodule

// *** hw/pec_top.sv ***
// The placing of the registers and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
module pec_top
	import pec_pkg::*;
(
	// clock and reset
	input  wire logic                       mclk_in,
	input  wire logic                       sys_rst_in,
	// pins
	input  wire logic [pec_pkg::A_W-1:0]    port_a_pin_in,
	input  wire logic [pec_pkg::B_W-1:0]    port_b_pin_in,
	// core state and event outputs
	input  wire logic                       core_sleep_in,
	output logic                            change_irq_pending_out,
	output logic                            change_irq_out,
	output logic                            core_wake_out,
	// axi4-lite write address
	input  wire logic [pec_pkg::ADDR_W-1:0] s_axi_awaddr_in,
	input  wire logic [2:0]                 s_axi_awprot_in,
	input  wire logic                       s_axi_awvalid_in,
	output logic                            s_axi_awready_out,
	// axi4-lite write data
	input  wire logic [31:0]                s_axi_wdata_in,
	input  wire logic [3:0]                 s_axi_wstrb_in,
	input  wire logic                       s_axi_wvalid_in,
	output logic                            s_axi_wready_out,
	// axi4-lite write response
	output logic [1:0]                      s_axi_bresp_out,
	output logic                            s_axi_bvalid_out,
	input  wire logic                       s_axi_bready_in,
	// axi4-lite read address
	input  wire logic [pec_pkg::ADDR_W-1:0] s_axi_araddr_in,
	input  wire logic [2:0]                 s_axi_arprot_in,
	input  wire logic                       s_axi_arvalid_in,
	output logic                            s_axi_arready_out,
	// axi4-lite read data
	output logic [31:0]                     s_axi_rdata_out,
	output logic [1:0]                      s_axi_rresp_out,
	output logic                            s_axi_rvalid_out,
	input  wire logic                       s_axi_rready_in
);
	import pec_pkg::*;

	// edge detectors, one per port
	pec_edge_if #(.W(A_W)) a_edges ();
	pec_edge_if #(.W(B_W)) b_edges ();

	// port a pins 5:0
	pec_edge_detect #(.W(A_W)) u_det_a (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.pins_in    (port_a_pin_in),
		.edges      (a_edges.det)
	);

	// port b pins 7:4; bit 0 of the bus is pin 4
	pec_edge_detect #(.W(B_W)) u_det_b (
		.mclk_in    (mclk_in),
		.sys_rst_in (sys_rst_in),
		.pins_in    (port_b_pin_in),
		.edges      (b_edges.det)
	);

	// software visible state
	// unimplemented bits have no flops, so a written one cannot stick
	logic [A_W-1:0] a_rise_q;
	logic [A_W-1:0] a_fall_q;
	logic [A_W-1:0] a_flag_q;
	logic [A_W-1:0] a_flag_d;
	logic [B_W-1:0] b_rise_q;
	logic [B_W-1:0] b_fall_q;
	logic [B_W-1:0] b_flag_q;
	logic [B_W-1:0] b_flag_d;
	logic           master_en_q;

	// write channel state
	// address and data may come in either order; each waits in its own flop
	pec_ch_e            wr_state_q;
	logic               aw_held_q;
	logic               w_held_q;
	logic [ADDR_W-1:0]  waddr_q;
	logic [31:0]        wdata_q;
	logic [3:0]         wstrb_q;
	logic [1:0]         bresp_q;

	// read channel state
	// one read in flight; the next address waits until the data is taken
	pec_ch_e            rd_state_q;
	logic [31:0]        rdata_q;
	logic [1:0]         rresp_q;

	// write channel decode
	// a write without lane 0 to a mapped offset still answers okay but decodes no register
	wire aw_take   = s_axi_awvalid_in & s_axi_awready_out;
	wire w_take    = s_axi_wvalid_in & s_axi_wready_out;
	wire wr_commit = aw_held_q & w_held_q & (wr_state_q == PEC_CH_IDLE);
	wire lane0     = wstrb_q[0];
	wire wr_a_rise = wr_commit && lane0 && (waddr_q == OFF_A_RISE);
	wire wr_a_fall = wr_commit && lane0 && (waddr_q == OFF_A_FALL);
	wire wr_a_flag = wr_commit && lane0 && (waddr_q == OFF_A_FLAGS);
	wire wr_b_rise = wr_commit && lane0 && (waddr_q == OFF_B_RISE);
	wire wr_b_fall = wr_commit && lane0 && (waddr_q == OFF_B_FALL);
	wire wr_b_flag = wr_commit && lane0 && (waddr_q == OFF_B_FLAGS);
	wire wr_ctrl   = wr_commit && lane0 && (waddr_q == OFF_CTRL);

	// unmapped addresses answer with slverr and change nothing
	wire wr_hit = (waddr_q == OFF_A_RISE) || (waddr_q == OFF_A_FALL) ||
	              (waddr_q == OFF_A_FLAGS) || (waddr_q == OFF_B_RISE) ||
	              (waddr_q == OFF_B_FALL) || (waddr_q == OFF_B_FLAGS) ||
	              (waddr_q == OFF_CTRL);

	// handshake outputs: each side held until the pair is complete
	// readies come from flops only, so they never wait on valid
	assign s_axi_awready_out = ~aw_held_q & (wr_state_q == PEC_CH_IDLE);
	assign s_axi_wready_out  = ~w_held_q & (wr_state_q == PEC_CH_IDLE);
	assign s_axi_bvalid_out  = (wr_state_q == PEC_CH_RESP);
	assign s_axi_bresp_out   = bresp_q;

	// only the low byte holds fields; narrower slices fall out here
	wire [7:0] wbyte = wdata_q[7:0];

	// hardware set terms, masked by the per-pin enables
	// enables gate the flags only; detection itself runs all the time
	wire [A_W-1:0] a_set = (a_rise_q & a_edges.rise) |
	                       (a_fall_q & a_edges.fall);
	wire [B_W-1:0] b_set = (b_rise_q & b_edges.rise) |
	                       (b_fall_q & b_edges.fall);

	// set wins over any write in the same cycle, so no edge is lost
	// the write replaces the old value and the set term is ored in after it
	assign a_flag_d = (wr_a_flag ? wbyte[A_LSB +: A_W] : a_flag_q) | a_set;
	assign b_flag_d = (wr_b_flag ? wbyte[B_LSB +: B_W] : b_flag_q) | b_set;

	// capture write address
	// held until commit so the decode sees one stable address
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			aw_held_q <= 1'b0;
			waddr_q   <= '0;
		end else if (aw_take) begin
			aw_held_q <= 1'b1;
			waddr_q   <= s_axi_awaddr_in;
		end else if (wr_commit) begin
			aw_held_q <= 1'b0;
		end
	end

	// capture write data
	// strobes are kept with the data; only lane 0 is ever looked at
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			w_held_q <= 1'b0;
			wdata_q  <= '0;
			wstrb_q  <= '0;
		end else if (w_take) begin
			w_held_q <= 1'b1;
			wdata_q  <= s_axi_wdata_in;
			wstrb_q  <= s_axi_wstrb_in;
		end else if (wr_commit) begin
			w_held_q <= 1'b0;
		end
	end

	// write response sequencing
	// bresp is fixed at commit and stays put while bvalid waits
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			wr_state_q <= PEC_CH_IDLE;
			bresp_q    <= RESP_OKAY;
		end else begin
			case (wr_state_q)
				PEC_CH_IDLE: begin
					if (wr_commit) begin
						wr_state_q <= PEC_CH_RESP;
						bresp_q    <= wr_hit ? RESP_OKAY : RESP_SLVERR;
					end
				end
				PEC_CH_RESP: begin
					if (s_axi_bready_in) begin
						wr_state_q <= PEC_CH_IDLE;
					end
				end
				default: begin
					wr_state_q <= PEC_CH_IDLE;
				end
			endcase
		end
	end

	// port a enables; bits 7:6 are not stored at all
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			a_rise_q <= REG_RST[A_LSB +: A_W];
			a_fall_q <= REG_RST[A_LSB +: A_W];
		end else begin
			if (wr_a_rise) begin
				a_rise_q <= wbyte[A_LSB +: A_W];
			end
			if (wr_a_fall) begin
				a_fall_q <= wbyte[A_LSB +: A_W];
			end
		end
	end

	// port b enables; bits 3:0 are not stored at all
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			b_rise_q <= REG_RST[B_LSB +: B_W];
			b_fall_q <= REG_RST[B_LSB +: B_W];
		end else begin
			if (wr_b_rise) begin
				b_rise_q <= wbyte[B_LSB +: B_W];
			end
			if (wr_b_fall) begin
				b_fall_q <= wbyte[B_LSB +: B_W];
			end
		end
	end

	// sticky flags, held until software writes a zero
	// writes and hardware sets are already merged in the next-value terms
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			a_flag_q <= REG_RST[A_LSB +: A_W];
			b_flag_q <= REG_RST[B_LSB +: B_W];
		end else begin
			a_flag_q <= a_flag_d;
			b_flag_q <= b_flag_d;
		end
	end

	// master enable lives in the control register
	// the pending bit beside it is status only and ignores writes
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			master_en_q <= REG_RST[CTRL_EN_BIT];
		end else if (wr_ctrl) begin
			master_en_q <= wbyte[CTRL_EN_BIT];
		end
	end

	// pending is a plain or of the flag flops, so it never leads them
	assign change_irq_pending_out = (|a_flag_q) | (|b_flag_q);
	// detection keeps running with the master off; only the request is gated
	assign change_irq_out = master_en_q & change_irq_pending_out;
	// wake is driven from the flags, so they hold the edge before the core runs
	assign core_wake_out = core_sleep_in & change_irq_out;

	// read channel decode
	// the address is used straight from the bus, only in the take cycle
	wire ar_take = s_axi_arvalid_in & s_axi_arready_out;
	wire [ADDR_W-1:0] raddr = s_axi_araddr_in;

	// each field placed at its documented position, all else zero
	wire [7:0] rd_a_rise = 8'(a_rise_q) << A_LSB;
	wire [7:0] rd_a_fall = 8'(a_fall_q) << A_LSB;
	wire [7:0] rd_a_flag = 8'(a_flag_q) << A_LSB;
	wire [7:0] rd_b_rise = 8'(b_rise_q) << B_LSB;
	wire [7:0] rd_b_fall = 8'(b_fall_q) << B_LSB;
	wire [7:0] rd_b_flag = 8'(b_flag_q) << B_LSB;
	wire [7:0] rd_ctrl   = (8'(master_en_q) << CTRL_EN_BIT) |
	                       (8'(change_irq_pending_out) << CTRL_PND_BIT);

	// read selection; unmapped reads return zero with slverr
	// offsets are all distinct, so the priority of the chain never matters
	logic [7:0] rd_byte;
	logic       rd_hit;
	always_comb begin
		rd_byte = 8'h00;
		rd_hit  = 1'b1;
		if (raddr == OFF_A_RISE) begin
			rd_byte = rd_a_rise;
		end else if (raddr == OFF_A_FALL) begin
			rd_byte = rd_a_fall;
		end else if (raddr == OFF_A_FLAGS) begin
			rd_byte = rd_a_flag;
		end else if (raddr == OFF_B_RISE) begin
			rd_byte = rd_b_rise;
		end else if (raddr == OFF_B_FALL) begin
			rd_byte = rd_b_fall;
		end else if (raddr == OFF_B_FLAGS) begin
			rd_byte = rd_b_flag;
		end else if (raddr == OFF_CTRL) begin
			rd_byte = rd_ctrl;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// read channel handshake outputs
	assign s_axi_arready_out = (rd_state_q == PEC_CH_IDLE);
	assign s_axi_rvalid_out  = (rd_state_q == PEC_CH_RESP);
	assign s_axi_rdata_out   = rdata_q;
	assign s_axi_rresp_out   = rresp_q;

	// read data is captured at the address handshake and held
	// a flag set after the take shows up on the next read, not this one
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			rd_state_q <= PEC_CH_IDLE;
			rdata_q    <= '0;
			rresp_q    <= RESP_OKAY;
		end else begin
			case (rd_state_q)
				PEC_CH_IDLE: begin
					if (ar_take) begin
						rd_state_q <= PEC_CH_RESP;
						rdata_q    <= {24'h000000, rd_byte};
						rresp_q    <= rd_hit ? RESP_OKAY : RESP_SLVERR;
					end
				end
				PEC_CH_RESP: begin
					if (s_axi_rready_in) begin
						rd_state_q <= PEC_CH_IDLE;
					end
				end
				default: begin
					rd_state_q <= PEC_CH_IDLE;
				end
			endcase
		end
	end

	// protection bits carry no meaning here
	// nor do write data above the low byte and the upper strobes
	wire unused_prot = ^{s_axi_awprot_in, s_axi_arprot_in, wdata_q[31:8], wstrb_q[3:1]};

endmodule

// *** verification/pec_top_props.sv ***
`timescale 1ns/1ps
// port-level relations of the change detector and its register bus
module pec_top_props
	import pec_pkg::*;
(
	// clock and reset
	input wire logic                    mclk_in,
	input wire logic                    sys_rst_in,
	// pins and events
	input wire logic [pec_pkg::A_W-1:0] port_a_pin_in,
	input wire logic [pec_pkg::B_W-1:0] port_b_pin_in,
	input wire logic                    core_sleep_in,
	input wire logic                    change_irq_pending_out,
	input wire logic                    change_irq_out,
	input wire logic                    core_wake_out,
	// bus handshakes
	input wire logic                    s_axi_awvalid_in,
	input wire logic                    s_axi_awready_out,
	input wire logic                    s_axi_wvalid_in,
	input wire logic                    s_axi_wready_out,
	input wire logic [1:0]              s_axi_bresp_out,
	input wire logic                    s_axi_bvalid_out,
	input wire logic                    s_axi_bready_in,
	input wire logic                    s_axi_arvalid_in,
	input wire logic                    s_axi_arready_out,
	input wire logic [31:0]             s_axi_rdata_out,
	input wire logic                    s_axi_rvalid_out,
	input wire logic                    s_axi_rready_in
);
	default clocking cb @(posedge mclk_in); endclocking
	default disable iff (sys_rst_in);
	logic [2:0] up_q;
	// cycles since reset; synchronisers clear in reset, so early history is not blamed
	always_ff @(posedge mclk_in) begin
		if (sys_rst_in) begin
			up_q <= 3'h0;
		end else if (up_q != 3'h7) begin
			up_q <= up_q + 3'h1;
		end
	end
	property p_pin_cause;
		$rose(change_irq_pending_out) && !$rose(s_axi_bvalid_out) && up_q == 3'h7
			|-> {$past(port_a_pin_in, 3), $past(port_b_pin_in, 3)} != {$past(port_a_pin_in, 4), $past(port_b_pin_in, 4)};
	endproperty
	a_pin_cause: assert property (p_pin_cause)
		else $error("pending rose without a pin change three cycles before");
	property p_pend_fall;
		$fell(change_irq_pending_out) |-> $rose(s_axi_bvalid_out);
	endproperty
	a_pend_fall: assert property (p_pend_fall)
		else $error("pending dropped without a write");
	property p_irq_gate;
		change_irq_out |-> change_irq_pending_out;
	endproperty
	a_irq_gate: assert property (p_irq_gate)
		else $error("interrupt without pending flag");
	property p_irq_rise;
		$rose(change_irq_out) |-> $rose(change_irq_pending_out) || $rose(s_axi_bvalid_out);
	endproperty
	a_irq_rise: assert property (p_irq_rise)
		else $error("interrupt rose with no new flag and no write");
	property p_wake;
		core_wake_out == (core_sleep_in && change_irq_out);
	endproperty
	a_wake: assert property (p_wake)
		else $error("wake does not follow sleep and interrupt");
	property p_wr_lat;
		s_axi_awvalid_in && s_axi_awready_out && s_axi_wvalid_in && s_axi_wready_out
			|=> !s_axi_awready_out ##1 s_axi_bvalid_out;
	endproperty
	a_wr_lat: assert property (p_wr_lat)
		else $error("write response not two cycles after take");
	property p_b_hold;
		s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write response dropped before taken");
	property p_rd_lat;
		s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out && !s_axi_arready_out;
	endproperty
	a_rd_lat: assert property (p_rd_lat)
		else $error("read data not one cycle after take");
	property p_r_hold;
		s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out && $stable(s_axi_rdata_out);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read data changed before taken");
	property p_r_upper;
		s_axi_rvalid_out |-> s_axi_rdata_out[31:8] == 24'h000000;
	endproperty
	a_r_upper: assert property (p_r_upper)
		else $error("read data upper bits not zero");
	c_wake: cover property (core_wake_out);
	c_pend: cover property ($rose(change_irq_pending_out) && !$rose(s_axi_bvalid_out));
	c_err: cover property (s_axi_bvalid_out && s_axi_bresp_out == RESP_SLVERR);
endmodule

bind pec_top pec_top_props i_props (.*);

// *** verification/pec_pin_model.sv ***
`timescale 1ns/1ps
// external pin source: levels follow the request after lag_in cycles
module pec_pin_model
	import pec_pkg::*;
(
	// clock
	input  wire logic                    mclk_in,
	// requested levels and lag
	input  wire logic [pec_pkg::A_W-1:0] a_tgt_in,
	input  wire logic [pec_pkg::B_W-1:0] b_tgt_in,
	input  wire logic [1:0]              lag_in,
	// pins
	output logic [pec_pkg::A_W-1:0]      port_a_pin_out = '0,
	output logic [pec_pkg::B_W-1:0]      port_b_pin_out = '0
);
	logic [1:0] cnt_q = 2'h0;
	// a slow source keeps its old level until the lag runs out
	always_ff @(posedge mclk_in) begin
		if ({a_tgt_in, b_tgt_in} == {port_a_pin_out, port_b_pin_out}) begin
			cnt_q <= 2'h0;
		end else if (cnt_q == lag_in) begin
			{port_a_pin_out, port_b_pin_out} <= {a_tgt_in, b_tgt_in};
			cnt_q <= 2'h0;
		end else begin
			cnt_q <= cnt_q + 2'h1;
		end
	end
endmodule

// *** verification/pin_edge_change_interrupt_tb.sv ***
`timescale 1ns/1ps
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin fails++; $display("CHECK FAILED %0t %s", $time, m); end end
// table of pin cases, then register, sleep and reset cases
module pin_edge_change_interrupt_tb;
	import pec_pkg::*;
	// one row: new pin levels, enables, expected flags
	typedef struct packed {
		logic [5:0] a;
		logic [3:0] b;
		logic [7:0] ar, af, br, bf, xa, xb;
	} pec_row_s;
	pec_row_s    rows [6] = '{
		'{6'h3F, 4'h0, 8'h3F, 8'h00, 8'h00, 8'h00, 8'h3F, 8'h00},
		'{6'h00, 4'h0, 8'h00, 8'h15, 8'h00, 8'h00, 8'h15, 8'h00},
		'{6'h00, 4'hF, 8'h00, 8'h00, 8'hA0, 8'h00, 8'h00, 8'hA0},
		'{6'h00, 4'h0, 8'h00, 8'h00, 8'h00, 8'h50, 8'h00, 8'h50},
		'{6'h2A, 4'h5, 8'h00, 8'h3F, 8'h00, 8'hF0, 8'h00, 8'h00},
		'{6'h15, 4'hA, 8'h14, 8'h22, 8'h80, 8'h10, 8'h36, 8'h90}};
	logic        mclk_in, sys_rst_in, core_sleep_in, change_irq_pending_out, change_irq_out, core_wake_out;
	logic [5:0]  port_a_pin_in, a_tgt;
	logic [3:0]  port_b_pin_in, b_tgt, s_axi_wstrb_in;
	logic [7:0]  s_axi_awaddr_in, s_axi_araddr_in, rd, seen;
	logic [2:0]  s_axi_awprot_in, s_axi_arprot_in;
	logic [31:0] s_axi_wdata_in, s_axi_rdata_out;
	logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, rsp, lag;
	logic        s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in, s_axi_wready_out, s_axi_bvalid_out;
	logic        s_axi_bready_in, s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
	int          fails = 0, check_count = 0, cyc = 0;
	pec_top i_dut (.*);
	pec_pin_model i_pins (.mclk_in, .a_tgt_in(a_tgt), .b_tgt_in(b_tgt), .lag_in(lag),
		.port_a_pin_out(port_a_pin_in), .port_b_pin_out(port_b_pin_in));
	initial begin
		mclk_in = 1'b0;
		forever #12.5 mclk_in = ~mclk_in;
	end
	// ceiling far above the few hundred cycles the sequence needs
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			give_verdict();
		end
	end
	task automatic give_verdict();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// one write; handshakes judged on values settled mid-cycle
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, bv, tb;
		tb = 1'b0;
		@(posedge mclk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= {24'h000000, d};
		s_axi_awvalid_in <= 1'b1;
		s_axi_wvalid_in <= 1'b1;
		while (!tb) begin
			@(negedge mclk_in);
			ta = s_axi_awvalid_in && s_axi_awready_out;
			tw = s_axi_wvalid_in && s_axi_wready_out;
			bv = s_axi_bvalid_out;
			tb = bv && s_axi_bready_in;
			rsp = s_axi_bresp_out;
			@(posedge mclk_in);
			if (ta) s_axi_awvalid_in <= 1'b0;
			if (tw) s_axi_wvalid_in <= 1'b0;
			s_axi_bready_in <= bv && !tb;
		end
	endtask
	// one read; rready comes a cycle late so the slave must hold its answer
	task automatic rdr(input logic [7:0] a);
		logic ta, rv, tr;
		tr = 1'b0;
		@(posedge mclk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'b1;
		while (!tr) begin
			@(negedge mclk_in);
			ta = s_axi_arvalid_in && s_axi_arready_out;
			rv = s_axi_rvalid_out;
			tr = rv && s_axi_rready_in;
			rd = s_axi_rdata_out[7:0];
			rsp = s_axi_rresp_out;
			@(posedge mclk_in);
			if (ta) s_axi_arvalid_in <= 1'b0;
			s_axi_rready_in <= rv && !tr;
		end
	endtask
	// new pin levels, then time for lag, synchroniser and flag
	task automatic pins(input logic [5:0] a, input logic [3:0] b, input logic [1:0] l);
		@(posedge mclk_in);
		a_tgt <= a;
		b_tgt <= b;
		lag <= l;
		repeat (8) @(posedge mclk_in);
	endtask
	initial begin
		sys_rst_in = 1'b1;
		s_axi_wstrb_in = 4'hF;
		{core_sleep_in, a_tgt, b_tgt, lag} = '0;
		{s_axi_awaddr_in, s_axi_araddr_in, s_axi_awprot_in, s_axi_arprot_in, s_axi_wdata_in} = '0;
		{s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		foreach (rows[i]) begin
			wr(OFF_A_RISE, rows[i].ar);
			wr(OFF_A_FALL, rows[i].af);
			wr(OFF_B_RISE, rows[i].br);
			wr(OFF_B_FALL, rows[i].bf);
			pins(rows[i].a, rows[i].b, 2'(i));
			`CHK(change_irq_pending_out, |{rows[i].xa, rows[i].xb}, "pending")
			rdr(OFF_A_FLAGS);
			`CHK(rd, rows[i].xa, "port a flags")
			wr(OFF_A_FLAGS, rd & (rd ^ 8'hFF));
			rdr(OFF_B_FLAGS);
			`CHK(rd, rows[i].xb, "port b flags")
			wr(OFF_B_FLAGS, rd & (rd ^ 8'hFF));
			`CHK(change_irq_pending_out, 1'b0, "cleared")
		end
		// the six port registers written all ones: only implemented bits stick
		for (int k = 0; k < 6; k++) begin
			wr(8'(4 * k), 8'hFF);
			rdr(8'(4 * k));
			`CHK(rd, (k < 3) ? 8'h3F : 8'hF0, "implemented bits")
		end
		`CHK(change_irq_out, 1'b0, "irq gated")
		core_sleep_in <= 1'b1;
		wr(OFF_CTRL, 8'h01);
		`CHK(core_wake_out, 1'b1, "wake")
		rdr(OFF_CTRL);
		`CHK(rd, 8'h03, "control")
		rdr(8'h1C);
		`CHK({rsp, rd}, {RESP_SLVERR, 8'h00}, "unmapped")
		wr(OFF_A_FLAGS, 8'h00);
		wr(OFF_B_FLAGS, 8'h00);
		`CHK(core_wake_out, 1'b0, "flags clear")
		// edges while asleep are in the flags by the time wake shows
		pins(6'h01, 4'hA, 2'h0);
		`CHK(core_wake_out, 1'b1, "wake on edge")
		rdr(OFF_A_FLAGS);
		`CHK(rd, 8'h14, "flags at wake")
		wr(OFF_CTRL, 8'h00);
		wr(OFF_A_FLAGS, 8'h00);
		core_sleep_in <= 1'b0;
		// pin edge timed to land on the same edge as a clearing write
		@(posedge mclk_in);
		a_tgt <= 6'h03;
		@(posedge mclk_in);
		wr(OFF_A_FLAGS, 8'h00);
		rdr(OFF_A_FLAGS);
		`CHK(rd, 8'h02, "set beats clear")
		// clear only what was seen: a flag raised after that read survives
		seen = rd;
		pins(6'h02, 4'hA, 2'h0);
		rdr(OFF_A_FLAGS);
		wr(OFF_A_FLAGS, rd & (seen ^ 8'hFF));
		rdr(OFF_A_FLAGS);
		`CHK(rd, 8'h01, "late flag kept")
		`CHK(change_irq_out, 1'b0, "no irq when disabled")
		sys_rst_in <= 1'b1;
		repeat (6) @(posedge mclk_in);
		sys_rst_in <= 1'b0;
		for (int k = 0; k < 7; k++) begin
			rdr(8'(4 * k));
			`CHK(rd, 8'h00, "reset value")
		end
		// writes that must change nothing: lane 0 off, then an unmapped address
		s_axi_wstrb_in <= 4'hE;
		wr(OFF_A_RISE, 8'hFF);
		`CHK(rsp, RESP_OKAY, "lane off answer")
		s_axi_wstrb_in <= 4'hF;
		wr(8'h1C, 8'hFF);
		`CHK(rsp, RESP_SLVERR, "unmapped write")
		rdr(OFF_A_RISE);
		`CHK({rsp, rd}, {RESP_OKAY, 8'h00}, "no lane, no change")
		give_verdict();
	end
endmodule
